// file: src/async_serial_pkg.sv
// Constants and shared helpers for the asynchronous serial port.
// Assumes byte-wide host access at eight consecutive offsets.
package async_serial_pkg;
  localparam logic [2:0] ADDR_RX_TX = 3'h0;
  localparam logic [2:0] ADDR_INT_EN = 3'h1;
  localparam logic [2:0] ADDR_INT_ID = 3'h2;
  localparam logic [2:0] ADDR_LINE_FMT = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTL = 3'h4;
  localparam logic [2:0] ADDR_LINE_FLAGS = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STATE = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;

  localparam int FMT_STOP_SEL = 2;
  localparam int FMT_PARITY_ON = 3;
  localparam int FMT_EVEN_SEL = 4;
  localparam int FMT_STICK_SEL = 5;
  localparam int FMT_BREAK = 6;
  localparam int FMT_DIV_ACCESS = 7;
  localparam int CTL_LOOP = 4;
  localparam int EN_RX_AVAIL = 0;
  localparam int EN_TX_EMPTY = 1;
  localparam int EN_LINE_STATUS = 2;
  localparam int EN_MODEM_STATUS = 3;

  localparam logic [7:0] INT_ID_NONE = 8'h01;
  localparam logic [7:0] INT_ID_LINE = 8'h06;
  localparam logic [7:0] INT_ID_RX = 8'h04;
  localparam logic [7:0] INT_ID_TX = 8'h02;
  localparam logic [7:0] INT_ID_MODEM = 8'h00;

  localparam logic [7:0] LINE_FMT_RST = 8'h00;
  localparam logic [4:0] MODEM_CTL_RST = 5'h00;
  localparam logic [3:0] INT_EN_RST = 4'h0;
  localparam logic [15:0] DIV_RST = 16'h0001;

  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_HALF = 4'h7;
  localparam logic [5:0] STOP_TICKS_ONE = 6'h10;
  localparam logic [5:0] STOP_TICKS_ONE_HALF = 6'h18;
  localparam logic [5:0] STOP_TICKS_TWO = 6'h20;
  localparam logic [1:0] LEN_FIVE = 2'h0;

  function automatic logic [7:0] len_mask(input logic [1:0] sel);
    len_mask = 8'hFF >> (2'h3 - sel);
  endfunction

  function automatic logic [2:0] last_index(input logic [1:0] sel);
    last_index = {1'b0, sel} + 3'h4;
  endfunction

  function automatic logic parity_bit(input logic [7:0] data, input logic [1:0] sel,
                                      input logic even, input logic stick);
    logic [7:0] masked;
    masked = data & len_mask(sel);
    if (stick) begin
      parity_bit = !even;
    end else begin
      parity_bit = even ? ^masked : ~^masked;
    end
  endfunction

  function automatic logic [5:0] stop_ticks(input logic sel, input logic [1:0] len);
    if (!sel) begin
      stop_ticks = STOP_TICKS_ONE;
    end else begin
      stop_ticks = (len == LEN_FIVE) ? STOP_TICKS_ONE_HALF : STOP_TICKS_TWO;
    end
  endfunction
endpackage

// file: src/async_serial_tx.sv
// Transmit serializer: start, data, optional parity, stop bits.
// Assumes a one-cycle tick at sixteen times the bit rate; load only while idle.
`timescale 1ns/100ps
module async_serial_tx
  import async_serial_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [7:0] data_i,
  input wire logic [1:0] len_sel_i,
  input wire logic stop_sel_i,
  input wire logic parity_on_i,
  input wire logic even_sel_i,
  input wire logic stick_sel_i,
  output logic serial_o,
  output logic busy_o
);
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } tx_state_t;

  tx_state_t state_reg;
  logic [5:0] cnt_reg;
  logic [2:0] idx_reg;
  logic [7:0] shift_reg;
  logic par_reg;

  wire logic bit_end = tick_i && (cnt_reg[3:0] == TICK_LAST);
  wire logic stop_end = tick_i && (cnt_reg == stop_ticks(stop_sel_i, len_sel_i) - 6'h01);
  wire logic last_bit = (idx_reg == last_index(len_sel_i));
  wire logic phase_end = (state_reg == TX_STOP) ? stop_end : bit_end;
  wire logic [5:0] cnt_next = (state_reg == TX_IDLE || phase_end) ? 6'h00 :
                              tick_i ? cnt_reg + 6'h01 : cnt_reg;

  assign serial_o = (state_reg == TX_START) ? 1'b0 :
                    (state_reg == TX_DATA) ? shift_reg[0] :
                    (state_reg == TX_PAR) ? par_reg : 1'b1;
  assign busy_o = (state_reg != TX_IDLE);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= TX_IDLE;
      cnt_reg <= 6'h00;
      idx_reg <= 3'h0;
      shift_reg <= 8'h00;
      par_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      case (state_reg)
        TX_IDLE: begin
          if (load_i) begin
            state_reg <= TX_START;
            shift_reg <= data_i;
            par_reg <= parity_bit(data_i, len_sel_i, even_sel_i, stick_sel_i);
          end
        end
        TX_START: begin
          if (bit_end) begin
            state_reg <= TX_DATA;
            idx_reg <= 3'h0;
          end
        end
        TX_DATA: begin
          if (bit_end) begin
            shift_reg <= shift_reg >> 1;
            idx_reg <= idx_reg + 3'h1;
            if (last_bit) begin
              state_reg <= parity_on_i ? TX_PAR : TX_STOP;
            end
          end
        end
        TX_PAR: begin
          if (bit_end) begin
            state_reg <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (stop_end) begin
            state_reg <= TX_IDLE;
          end
        end
        default: begin
          state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_start_bit: assert property (state_reg == TX_IDLE && load_i |=> !serial_o)
    else $error("start bit not driven low after load");
  a_char_len: assert property (state_reg == TX_DATA && bit_end && last_bit
    |=> state_reg != TX_DATA)
    else $error("data phase longer than character length");
  a_stick_par: assert property (state_reg == TX_PAR && stick_sel_i && parity_on_i
    && $stable(stick_sel_i) && $stable(even_sel_i) |-> serial_o == !even_sel_i)
    else $error("stick parity bit wrong");
  a_long_stop: assert property (state_reg == TX_STOP && tick_i && cnt_reg == 6'h0F
    && stop_sel_i |=> state_reg == TX_STOP)
    else $error("long stop ended after one bit");
endmodule

// file: src/async_serial_port.sv
// Asynchronous serial port: host byte registers, baud generator, receiver.
// Assumes host strobes and serial/modem inputs synchronous to core_clk_i.
`timescale 1ns/100ps
module async_serial_port
  import async_serial_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic cts_i,
  input wire logic dsr_i,
  input wire logic ri_i,
  input wire logic dcd_i,
  output logic dtr_o,
  output logic rts_o,
  output logic out1_o,
  output logic out2_o
);
  if (DIV_W < 9 || DIV_W > 16) begin : g_bad_width
    $error("DIV_W must lie between 9 and 16");
  end

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PAR = 5'b01000,
    RX_STOP = 5'b10000
  } rx_state_t;

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] baud_cnt_reg;
  logic baud_tick_reg;
  logic [3:0] int_en_reg;
  logic [7:0] line_fmt_reg;
  logic [4:0] modem_ctl_reg;
  logic [7:0] scratch_reg;
  logic [7:0] tx_hold_reg;
  logic tx_holding_empty_reg;
  logic tx_irq_reg;
  logic [7:0] rx_buf_reg;
  logic rx_byte_ready_reg;
  logic overrun_reg;
  logic parity_fault_reg;
  logic framing_fault_reg;
  logic line_break_flag_reg;
  logic [3:0] modem_delta_reg;
  logic [3:0] modem_prev_reg;
  rx_state_t rx_state_reg;
  logic [3:0] rx_cnt_reg;
  logic [2:0] rx_idx_reg;
  logic [7:0] rx_shift_reg;
  logic rx_par_reg;
  logic rx_prev_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;
  logic txd_reg;
  logic [3:0] modem_out_reg;
  logic tx_serial;
  logic tx_busy;

  // Decode; the access bit only re-banks offsets 0 and 1
  wire logic div_access = line_fmt_reg[FMT_DIV_ACCESS];
  wire logic loop = modem_ctl_reg[CTL_LOOP];
  wire logic at_data = (addr_i == ADDR_RX_TX);
  wire logic at_en = (addr_i == ADDR_INT_EN);
  wire logic rx_buf_rd = rd_i && at_data && !div_access;
  wire logic tx_hold_wr = wr_i && at_data && !div_access;
  wire logic int_en_wr = wr_i && at_en && !div_access;
  wire logic div_lo_wr = wr_i && at_data && div_access;
  wire logic div_hi_wr = wr_i && at_en && div_access;
  wire logic id_rd = rd_i && (addr_i == ADDR_INT_ID);
  wire logic flags_rd = rd_i && (addr_i == ADDR_LINE_FLAGS);
  wire logic modem_rd = rd_i && (addr_i == ADDR_MODEM_STATE);

  wire logic [1:0] len_sel = line_fmt_reg[1:0];
  wire logic parity_on = line_fmt_reg[FMT_PARITY_ON];
  wire logic even_sel = line_fmt_reg[FMT_EVEN_SEL];
  wire logic stick_sel = line_fmt_reg[FMT_STICK_SEL];

  // Baud generator; divisor 0 behaves as 2 to the power DIV_W (65536 at DIV_W 16)
  wire logic baud_wrap = (baud_cnt_reg >= div_reg - DIV_W'(1));

  // Transmit path; break overrides the serializer
  wire logic tx_load = !tx_busy && !tx_holding_empty_reg;
  wire logic line_int = line_fmt_reg[FMT_BREAK] ? 1'b0 : tx_serial;
  wire logic rx_line = loop ? line_int : rxd_i;
  wire logic tx_shifter_empty = tx_holding_empty_reg && !tx_busy;

  // Modem inputs ordered carrier, ring, set ready, clear to send
  wire logic [3:0] modem_in = loop ? {modem_ctl_reg[3], modem_ctl_reg[2], modem_ctl_reg[0],
                                      modem_ctl_reg[1]} : {dcd_i, ri_i, dsr_i, cts_i};
  wire logic [3:0] modem_chg = modem_in ^ modem_prev_reg;
  wire logic [3:0] modem_set = {modem_chg[3], modem_prev_reg[2] && !modem_in[2],
                                modem_chg[1:0]};

  // Receiver sampling at bit centres
  wire logic rx_bit_end = baud_tick_reg && (rx_cnt_reg == TICK_LAST);
  wire logic rx_done = (rx_state_reg == RX_STOP) && rx_bit_end;
  wire logic par_err = parity_on &&
                       (rx_par_reg != parity_bit(rx_shift_reg, len_sel, even_sel, stick_sel));
  wire logic brk_seen = (rx_shift_reg == 8'h00) && !rx_line && !(parity_on && rx_par_reg);

  // Source id priority: line status, data, holding empty, modem
  wire logic line_pend = int_en_reg[EN_LINE_STATUS] &&
                         (overrun_reg || parity_fault_reg || framing_fault_reg ||
                          line_break_flag_reg);
  wire logic rx_pend = int_en_reg[EN_RX_AVAIL] && rx_byte_ready_reg;
  wire logic tx_pend = int_en_reg[EN_TX_EMPTY] && tx_irq_reg;
  wire logic modem_pend = int_en_reg[EN_MODEM_STATUS] && (modem_delta_reg != 4'h0);
  wire logic [7:0] int_source_id = line_pend ? INT_ID_LINE : rx_pend ? INT_ID_RX :
                                   tx_pend ? INT_ID_TX : modem_pend ? INT_ID_MODEM :
                                   INT_ID_NONE;
  wire logic pending = !int_source_id[0];

  wire logic [7:0] line_flags = {1'b0, tx_shifter_empty, tx_holding_empty_reg,
                                 line_break_flag_reg, framing_fault_reg, parity_fault_reg,
                                 overrun_reg, rx_byte_ready_reg};
  wire logic [7:0] rd_mux =
    at_data ? (div_access ? div_reg[7:0] : rx_buf_reg) :
    at_en ? (div_access ? 8'(div_reg >> 8) : {4'h0, int_en_reg}) :
    (addr_i == ADDR_INT_ID) ? int_source_id :
    (addr_i == ADDR_LINE_FMT) ? line_fmt_reg :
    (addr_i == ADDR_MODEM_CTL) ? {3'h0, modem_ctl_reg} :
    (addr_i == ADDR_LINE_FLAGS) ? line_flags :
    (addr_i == ADDR_MODEM_STATE) ? {modem_in, modem_delta_reg} : scratch_reg;

  // Transmit-empty event; a new write or a read naming it clears it, set wins
  wire logic tx_irq_set = (tx_load && !tx_hold_wr) ||
                          (int_en_wr && wdata_i[EN_TX_EMPTY] && !int_en_reg[EN_TX_EMPTY] &&
                           tx_holding_empty_reg);
  wire logic tx_irq_clr = tx_hold_wr || (id_rd && int_source_id == INT_ID_TX);

  async_serial_tx u_tx (
    .clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .tick_i(baud_tick_reg),
    .load_i(tx_load),
    .data_i(tx_hold_reg),
    .len_sel_i(len_sel),
    .stop_sel_i(line_fmt_reg[FMT_STOP_SEL]),
    .parity_on_i(parity_on),
    .even_sel_i(even_sel),
    .stick_sel_i(stick_sel),
    .serial_o(tx_serial),
    .busy_o(tx_busy)
  );

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      baud_cnt_reg <= '0;
      baud_tick_reg <= 1'b0;
    end else begin
      baud_cnt_reg <= baud_wrap ? '0 : baud_cnt_reg + DIV_W'(1);
      baud_tick_reg <= baud_wrap;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_reg <= DIV_W'(DIV_RST);
      int_en_reg <= INT_EN_RST;
      line_fmt_reg <= LINE_FMT_RST;
      modem_ctl_reg <= MODEM_CTL_RST;
      scratch_reg <= 8'h00;
      tx_hold_reg <= 8'h00;
    end else if (wr_i) begin
      if (div_lo_wr) div_reg[7:0] <= wdata_i;
      if (div_hi_wr) div_reg[DIV_W-1:8] <= wdata_i[DIV_W-9:0];
      if (int_en_wr) int_en_reg <= wdata_i[3:0];
      if (tx_hold_wr) tx_hold_reg <= wdata_i;
      if (addr_i == ADDR_LINE_FMT) line_fmt_reg <= wdata_i;
      if (addr_i == ADDR_MODEM_CTL) modem_ctl_reg <= wdata_i[4:0];
      if (addr_i == ADDR_SCRATCH) scratch_reg <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_holding_empty_reg <= 1'b1;
      tx_irq_reg <= 1'b0;
      rx_byte_ready_reg <= 1'b0;
      overrun_reg <= 1'b0;
      parity_fault_reg <= 1'b0;
      framing_fault_reg <= 1'b0;
      line_break_flag_reg <= 1'b0;
      modem_delta_reg <= 4'h0;
      modem_prev_reg <= 4'h0;
      rx_buf_reg <= 8'h00;
    end else begin
      tx_holding_empty_reg <= tx_hold_wr ? 1'b0 : (tx_load || tx_holding_empty_reg);
      tx_irq_reg <= tx_irq_set || (tx_irq_reg && !tx_irq_clr);
      rx_byte_ready_reg <= rx_done || (rx_byte_ready_reg && !rx_buf_rd);
      overrun_reg <= (rx_done && rx_byte_ready_reg && !rx_buf_rd) ||
                     (overrun_reg && !flags_rd);
      parity_fault_reg <= (rx_done && par_err) || (parity_fault_reg && !flags_rd);
      framing_fault_reg <= (rx_done && !rx_line) || (framing_fault_reg && !flags_rd);
      line_break_flag_reg <= (rx_done && brk_seen) || (line_break_flag_reg && !flags_rd);
      modem_delta_reg <= modem_set | (modem_delta_reg & ~{4{modem_rd}});
      modem_prev_reg <= modem_in;
      if (rx_done) rx_buf_reg <= rx_shift_reg;
    end
  end

  // Start edge checked every clock, then counted in ticks
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_idx_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_par_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rx_line;
      if (rx_state_reg != RX_IDLE && baud_tick_reg) rx_cnt_reg <= rx_cnt_reg + 4'h1;
      case (rx_state_reg)
        RX_IDLE: begin
          rx_cnt_reg <= 4'h0;
          if (rx_prev_reg && !rx_line) rx_state_reg <= RX_START;
        end
        RX_START: begin
          if (baud_tick_reg && rx_cnt_reg == TICK_HALF) begin
            // Glitches shorter than half a bit are dropped
            rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
            rx_cnt_reg <= 4'h0;
            rx_idx_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
          end
        end
        RX_DATA: begin
          if (rx_bit_end) begin
            rx_shift_reg[rx_idx_reg] <= rx_line;
            rx_idx_reg <= rx_idx_reg + 3'h1;
            if (rx_idx_reg == last_index(len_sel)) begin
              rx_state_reg <= parity_on ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_bit_end) begin
            rx_par_reg <= rx_line;
            rx_state_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_bit_end) rx_state_reg <= RX_IDLE;
        end
        default: begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // Every output is a flop; loopback parks the line idle and outputs inactive
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      txd_reg <= 1'b1;
      modem_out_reg <= 4'h0;
    end else begin
      if (rd_i) rdata_reg <= rd_mux;
      irq_reg <= pending;
      txd_reg <= loop ? 1'b1 : line_int;
      modem_out_reg <= loop ? 4'h0 : modem_ctl_reg[3:0];
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign txd_o = txd_reg;
  assign dtr_o = modem_out_reg[0];
  assign rts_o = modem_out_reg[1];
  assign out1_o = modem_out_reg[2];
  assign out2_o = modem_out_reg[3];

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_two_quiet_then_tick;
    !baud_tick_reg ##1 !baud_tick_reg ##1 baud_tick_reg;
  endsequence

  a_baud_period: assert property (baud_tick_reg && div_reg == DIV_W'(3) && !div_lo_wr
    && !div_hi_wr |=> s_two_quiet_then_tick)
    else $error("tick spacing differs from divisor");
  a_false_start: assert property (rx_state_reg == RX_START && baud_tick_reg
    && rx_cnt_reg == TICK_HALF && rx_line |=> rx_state_reg == RX_IDLE)
    else $error("receiver kept a false start");
  a_rx_read: assert property (rx_buf_rd |=> rdata_o == $past(rx_buf_reg))
    else $error("receive buffer read wrong");
  a_div_bank: assert property (div_lo_wr |=> div_reg[7:0] == $past(wdata_i))
    else $error("divisor low byte not written");
  a_en_upper: assert property (rd_i && at_en && !div_access |=> rdata_o[7:4] == 4'h0)
    else $error("enable upper bits not zero");
  a_id_code: assert property (id_rd |=> rdata_o[7:3] == 5'h00
    && rdata_o[0] == !$past(pending))
    else $error("source id read wrong");
  a_break_out: assert property (line_fmt_reg[FMT_BREAK] && !loop |=> !txd_o)
    else $error("break not driven");
  a_dtr_follow: assert property (!loop |=> dtr_o == $past(modem_ctl_reg[0]))
    else $error("terminal ready does not follow control");
  a_overrun_set: assert property (rx_done && rx_byte_ready_reg && !rx_buf_rd
    |=> overrun_reg && rx_byte_ready_reg)
    else $error("overrun not flagged");
  a_flags_top: assert property (flags_rd |=> !rdata_o[7] && (!rdata_o[6] || rdata_o[5]))
    else $error("line flags inconsistent");
  a_loop_idle: assert property (loop |=> txd_o && !dtr_o && !rts_o)
    else $error("loopback did not idle the line");
endmodule

// file: verification/serial_peer_model.sv
// Remote serial device: drives frames onto rxd_o, captures frames seen on txd_i.
// Assumes bit time in core clocks and frame length set by the bench.
`timescale 1ns/100ps
module serial_peer_model (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic [15:0] bit_clks_i,
  input wire logic [3:0] nbits_i,
  output logic rxd_o
);
  logic [11:0] got;
  int got_cnt = 0;
  initial rxd_o = 1'b1;
  // Samples on the falling clock, clear of the edge that launches txd
  always begin
    @(negedge clk_i);
    if (txd_i === 1'b0) begin
      repeat (bit_clks_i / 2) @(negedge clk_i);
      got = '0;
      for (int i = 0; i < nbits_i; i++) begin
        repeat (bit_clks_i) @(negedge clk_i);
        got[i] = txd_i;
      end
      got_cnt++;
    end
  end
  task automatic send(input logic [11:0] f, input int n);
    @(posedge clk_i);
    #1 rxd_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (bit_clks_i) @(posedge clk_i);
      #1 rxd_o = f[i];
    end
    repeat (bit_clks_i) @(posedge clk_i);
    #1 rxd_o = 1'b1;
  endtask
  // Short low pulse that must not start a frame
  task automatic glitch(input int c);
    @(posedge clk_i);
    #1 rxd_o = 1'b0;
    repeat (c) @(posedge clk_i);
    #1 rxd_o = 1'b1;
  endtask
endmodule

// file: verification/async_serial_port_tb_top.sv
// Self-checking bench: registers, framing both ways, faults, modem, loopback.
// Assumes the peer model on the line and divisor 2, so 32 clocks a bit.
`timescale 1ns/100ps
module async_serial_port_tb_top import async_serial_pkg::*;;
  localparam logic [63:0] RSTV = 64'h0000600000010000;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wdata = '0;
  logic [7:0] rdata, v, d;
  logic irq, rxd, txd, dtr, rts, out1, out2;
  logic cts = 1'b0, dsr = 1'b0, ri = 1'b0, dcd = 1'b0;
  logic [3:0] nb = 4'hA;
  logic [11:0] f;
  int miscompares = 0;
  int tests_run = 0;
  int n, base;
  async_serial_port i_async_serial_port (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata), .irq_o(irq),
    .rxd_i(rxd), .txd_o(txd), .cts_i(cts), .dsr_i(dsr), .ri_i(ri), .dcd_i(dcd),
    .dtr_o(dtr), .rts_o(rts), .out1_o(out1), .out2_o(out2));
  serial_peer_model i_serial_peer_model (.clk_i(core_clk_i), .txd_i(txd),
    .bit_clks_i(16'h0020), .nbits_i(nb), .rxd_o(rxd));
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] x);
    @(posedge core_clk_i);
    #1 addr = a;
    wdata = x;
    wr = 1'b1;
    @(posedge core_clk_i);
    #1 wr = 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, output logic [7:0] x);
    @(posedge core_clk_i);
    #1 addr = a;
    rd = 1'b1;
    @(posedge core_clk_i);
    #1 rd = 1'b0;
    x = rdata;
  endtask
  task automatic cr(input logic [2:0] a, input logic [7:0] e);
    rreg(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask
  // Flags are read until one in m shows; the read value is kept in v
  task automatic poll(input logic [7:0] m);
    for (int k = 0; k < 1000; k++) begin
      rreg(ADDR_LINE_FLAGS, v);
      if ((v & m) !== 8'h00) return;
    end
    miscompares++;
    end_of_test();
  endtask
  task automatic wait_got(input int c);
    for (int k = 0; k < 2000; k++) begin
      @(posedge core_clk_i);
      if (i_serial_peer_model.got_cnt >= c) return;
    end
    miscompares++;
    end_of_test();
  endtask
  function automatic logic [11:0] frame(input logic [7:0] x, input int len, input int m,
                                        output int cnt);
    logic [7:0] dm;
    dm = x & (8'hFF >> (3 - len));
    frame = {4'h0, dm};
    cnt = len + 5;
    if (m != 0) begin
      frame[cnt] = (m >= 3) ? (m == 3) : ((m == 2) ? ^dm : ~^dm);
      cnt++;
    end
    frame[cnt] = 1'b1;
    cnt++;
  endfunction
  initial begin
    d = 8'($urandom(32'h3C92));
    repeat (6) @(posedge core_clk_i);
    #1 rstn_i = 1'b1;
    for (int a = 1; a < 8; a++) cr(3'(a), RSTV[a*8 +: 8]);
    wreg(ADDR_LINE_FMT, 8'h80);
    cr(ADDR_RX_TX, 8'h01);
    wreg(ADDR_RX_TX, 8'h03);
    repeat (8) @(posedge core_clk_i);
    wreg(ADDR_INT_EN, 8'h5A);
    cr(ADDR_INT_EN, 8'h5A);
    wreg(ADDR_INT_EN, 8'h00);
    wreg(ADDR_RX_TX, 8'h02);
    cr(ADDR_RX_TX, 8'h02);
    cr(ADDR_INT_EN, 8'h00);
    wreg(ADDR_LINE_FMT, 8'h00);
    wreg(ADDR_INT_EN, 8'hF5);
    cr(ADDR_INT_EN, 8'h05);
    wreg(ADDR_INT_EN, 8'h00);
    wreg(ADDR_INT_ID, 8'hFF);
    cr(ADDR_INT_ID, 8'h01);
    wreg(ADDR_SCRATCH, d);
    cr(ADDR_SCRATCH, d);
    wreg(ADDR_MODEM_CTL, 8'hEF);
    cr(ADDR_MODEM_CTL, 8'h0F);
    chk({dtr, rts, out1, out2}, 16'h000F);
    wreg(ADDR_MODEM_CTL, 8'h00);
    // Every length against every parity mode, out then in
    for (int len = 0; len < 4; len++) begin
      for (int m = 0; m < 5; m++) begin
        d = 8'($urandom);
        f = frame(d, len, m, n);
        nb = 4'(n);
        wreg(ADDR_LINE_FMT, {2'b00, m >= 3, m == 2 || m == 4, m != 0, 1'($urandom), 2'(len)});
        base = i_serial_peer_model.got_cnt;
        wreg(ADDR_RX_TX, d);
        wait_got(base + 1);
        chk({4'h0, i_serial_peer_model.got}, {4'h0, f});
        i_serial_peer_model.send(f, n);
        poll(8'h01);
        chk({8'h00, v}, 16'h0061);
        cr(ADDR_RX_TX, d & (8'hFF >> (3 - len)));
      end
    end
    wreg(ADDR_LINE_FMT, 8'h0B);
    f = frame(d, 3, 1, n);
    i_serial_peer_model.send(f ^ 12'h100, n);
    poll(8'h01);
    chk({8'h00, v}, 16'h0065);
    rreg(ADDR_RX_TX, v);
    i_serial_peer_model.send(f & 12'hDFF, n);
    poll(8'h01);
    chk({8'h00, v}, 16'h0069);
    rreg(ADDR_RX_TX, v);
    i_serial_peer_model.send(12'h000, n);
    poll(8'h01);
    chk({8'h00, v & 8'h11}, 16'h0011);
    rreg(ADDR_RX_TX, v);
    i_serial_peer_model.send(f, n);
    i_serial_peer_model.send(frame(~d, 3, 1, n), n);
    poll(8'h01);
    chk({8'h00, v & 8'h03}, 16'h0003);
    cr(ADDR_RX_TX, ~d);
    i_serial_peer_model.glitch(8);
    repeat (400) @(posedge core_clk_i);
    cr(ADDR_LINE_FLAGS, 8'h60);
    wreg(ADDR_INT_EN, 8'h01);
    i_serial_peer_model.send(f, n);
    poll(8'h01);
    chk({15'h0, irq}, 16'h0001);
    cr(ADDR_INT_ID, 8'h04);
    rreg(ADDR_RX_TX, v);
    cr(ADDR_INT_ID, 8'h01);
    wreg(ADDR_INT_EN, 8'h02);
    cr(ADDR_INT_ID, 8'h02);
    cr(ADDR_INT_ID, 8'h01);
    wreg(ADDR_INT_EN, 8'h00);
    @(posedge core_clk_i);
    #1 {cts, dsr, ri, dcd} = 4'hF;
    cr(ADDR_MODEM_STATE, 8'hFB);
    ri = 1'b0;
    cr(ADDR_MODEM_STATE, 8'hB4);
    {cts, dsr, dcd} = 3'h0;
    cr(ADDR_MODEM_STATE, 8'h0B);
    // Loopback: line must stay idle while the receiver hears our own byte
    wreg(ADDR_MODEM_CTL, 8'h13);
    @(posedge core_clk_i);
    #1 chk({txd, dtr}, 16'h0002);
    cr(ADDR_MODEM_STATE, 8'h33);
    wreg(ADDR_LINE_FMT, 8'h03);
    base = i_serial_peer_model.got_cnt;
    wreg(ADDR_RX_TX, d);
    poll(8'h01);
    cr(ADDR_RX_TX, d);
    chk(16'(i_serial_peer_model.got_cnt - base), 16'h0000);
    wreg(ADDR_MODEM_CTL, 8'h00);
    wreg(ADDR_LINE_FMT, 8'h43);
    repeat (2) @(posedge core_clk_i);
    #1 chk({15'h0, txd}, 16'h0000);
    wreg(ADDR_LINE_FMT, 8'h03);
    end_of_test();
  end
endmodule
